/* design/mcit_consts.vh */
`ifndef MCIT_CONSTS_VH
`define MCIT_CONSTS_VH

// ********************************
// Reset values and field positions
// ********************************
`define MCIT_PC_RESET      16'h0000
`define MCIT_BYTE_RESET    8'h00
`define MCIT_SFR_BIT       7
`define MCIT_PAGE_LSB      11
`define MCIT_DJNZ_LAST     8'h01

// ********************************
// Instruction lengths and base cycles
// ********************************
`define MCIT_LEN1          2'h1
`define MCIT_LEN2          2'h2
`define MCIT_LEN3          2'h3
`define MCIT_CYC1          3'h1
`define MCIT_CYC2          3'h2
`define MCIT_CYC3          3'h3
`define MCIT_CYC4          3'h4
`define MCIT_STEP0         3'h0
`define MCIT_STEP1         3'h1
`define MCIT_STEP2         3'h2

// ********************************
// Instruction classes
// ********************************
`define MCIT_CLS_PLAIN     4'h0
`define MCIT_CLS_CONDFLAG  4'h1
`define MCIT_CLS_CONDBIT   4'h2
`define MCIT_CLS_CJNE      4'h3
`define MCIT_CLS_DJNZ      4'h4
`define MCIT_CLS_SJMP      4'h5
`define MCIT_CLS_PAGEJMP   4'h6
`define MCIT_CLS_PAGECALL  4'h7
`define MCIT_CLS_LONGJMP   4'h8
`define MCIT_CLS_LONGCALL  4'h9
`define MCIT_CLS_JIND      4'hA
`define MCIT_CLS_MOVC      4'hB
`define MCIT_CLS_MOVX      4'hC
`define MCIT_CLS_LDDP      4'hD
`define MCIT_CLS_FOREIGN   4'hE

// ********************************
// Opcodes and opcode patterns
// ********************************
`define MCIT_OP_NOP        8'h00
`define MCIT_OP_SPARE      8'hA5
`define MCIT_OP_CLR_A      8'hE4
`define MCIT_OP_CPL_A      8'hF4
`define MCIT_OP_ROT_L      8'h23
`define MCIT_OP_ROT_LC     8'h33
`define MCIT_OP_ROT_R      8'h03
`define MCIT_OP_ROT_RC     8'h13
`define MCIT_OP_SWAP       8'hC4
`define MCIT_OP_XRL_DIMM   8'h63
`define MCIT_OP_MOV_A_RN   8'b1110_1???
`define MCIT_OP_MOV_RN_A   8'b1111_1???
`define MCIT_OP_XCH_RN     8'b1100_1???
`define MCIT_OP_MOV_RN_D   8'b1010_1???
`define MCIT_OP_MOV_RN_I   8'b0111_1???
`define MCIT_OP_MOV_D_RN   8'b1000_1???
`define MCIT_OP_CJNE_RN    8'b1011_1???
`define MCIT_OP_DJNZ_RN    8'b1101_1???
`define MCIT_OP_MOV_A_RI   8'b1110_011?
`define MCIT_OP_MOV_RI_A   8'b1111_011?
`define MCIT_OP_XCH_RI     8'b1100_011?
`define MCIT_OP_XCHD_RI    8'b1101_011?
`define MCIT_OP_MOV_D_RI   8'b1000_011?
`define MCIT_OP_MOV_RI_D   8'b1010_011?
`define MCIT_OP_MOV_RI_I   8'b0111_011?
`define MCIT_OP_CJNE_RI    8'b1011_011?
`define MCIT_OP_AJMP       8'b???0_0001
`define MCIT_OP_ACALL      8'b???1_0001
`define MCIT_OP_MOVX       8'b111?_00??
`define MCIT_OP_MOV_A_D    8'hE5
`define MCIT_OP_MOV_A_I    8'h74
`define MCIT_OP_MOV_D_A    8'hF5
`define MCIT_OP_MOV_D_D    8'h85
`define MCIT_OP_MOV_D_I    8'h75
`define MCIT_OP_MOV_DP     8'h90
`define MCIT_OP_MOVC_DP    8'h93
`define MCIT_OP_MOVC_PC    8'h83
`define MCIT_OP_PUSH       8'hC0
`define MCIT_OP_POP        8'hD0
`define MCIT_OP_XCH_D      8'hC5
`define MCIT_OP_CLR_C      8'hC3
`define MCIT_OP_SETB_C     8'hD3
`define MCIT_OP_CPL_C      8'hB3
`define MCIT_OP_CLR_B      8'hC2
`define MCIT_OP_SETB_B     8'hD2
`define MCIT_OP_CPL_B      8'hB2
`define MCIT_OP_ANL_CB     8'h82
`define MCIT_OP_ANL_CNB    8'hB0
`define MCIT_OP_ORL_CB     8'h72
`define MCIT_OP_ORL_CNB    8'hA0
`define MCIT_OP_MOV_CB     8'hA2
`define MCIT_OP_MOV_BC     8'h92
`define MCIT_OP_JC         8'h40
`define MCIT_OP_JNC        8'h50
`define MCIT_OP_JZ         8'h60
`define MCIT_OP_JNZ        8'h70
`define MCIT_OP_JB         8'h20
`define MCIT_OP_JNB        8'h30
`define MCIT_OP_JBC        8'h10
`define MCIT_OP_LCALL      8'h12
`define MCIT_OP_LJMP       8'h02
`define MCIT_OP_SJMP       8'h80
`define MCIT_OP_JMP_IND    8'h73
`define MCIT_OP_CJNE_AD    8'hB5
`define MCIT_OP_CJNE_AI    8'hB4
`define MCIT_OP_DJNZ_D     8'hD5

`endif

/* design/mcit_step_counter.v */
`include "mcit_consts.vh"

module mcit_step_counter #(
	parameter STEP_W = 3
) (
	// Clock and reset
	input  wire              clock,
	input  wire              rst_n,
	// Control
	input  wire              clear,
	input  wire              advance,
	// Cycle index within the instruction
	output reg  [STEP_W-1:0] step
);

	// Clear wins so a finishing instruction always restarts at its opcode
	always @(posedge clock) begin
		if (!rst_n) begin
			step <= {STEP_W{1'b0}};
		end else if (clear) begin
			step <= {STEP_W{1'b0}};
		end else if (advance) begin
			step <= step + {{(STEP_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

/* design/mcit_target_calc.v */
`include "mcit_consts.vh"

module mcit_target_calc (
	// Instruction context
	input  wire [15:0] nextAddr,
	input  wire [7:0]  opcode,
	input  wire [7:0]  relByte,
	input  wire [7:0]  byte1,
	input  wire [7:0]  byte2,
	// Core state
	input  wire [7:0]  accIn,
	input  wire [15:0] dataPointerIn,
	// Targets
	output wire [15:0] relTarget,
	output wire [15:0] pageTarget,
	output wire [15:0] longTarget,
	output wire [15:0] indTarget
);

	// Signed offset from the byte after the whole instruction
	assign relTarget  = nextAddr + {{8{relByte[7]}}, relByte};
	// Page stays that of the following instruction, wrap included
	assign pageTarget = {nextAddr[15:`MCIT_PAGE_LSB], opcode[7:5], byte1};
	assign longTarget = {byte1, byte2};
	assign indTarget  = dataPointerIn + {8'h00, accIn};

endmodule

/* design/mcit_instr_decoder.v */
// Summary of operation
// - Accumulator clear/complement/swap/rotates: one byte, cycle
// - XOR immediate into direct byte: three/three
// - Register moves 1, indirect 2, immediate/direct 2/2
// - Direct-to-direct and immediate-to-direct moves: three/three
// - Data pointer constant load: three bytes, cycles
// - Code byte read at A plus base: 1/3
// - External data moves: one byte, three cycles
// - Push and pop direct byte: two/two
// - Exchanges: register 1, indirect 2, direct 2/2
// - Carry ops one cycle, direct bit ops 2/2
// - Carry/zero conditional jumps: two bytes, 2/3
// - Bit jumps 3/4; set-bit variant clears bit
// - Absolute, long, short, indirect jump timings fixed
// - Compare-jump three bytes; 4/5 or 3/4 cycles
// - Decrement-jump: register 2/3, direct byte 3/4
// - Spare opcode behaves as one-cycle no-operation
// - Relative target: next address plus signed offset
// - Direct address low half RAM, upper special
// - Page target replaces low 11 address bits
// - Long target: full sixteen-bit program address
// - Untaken conditional branch finishes one cycle sooner
// - Bank select picks eight-byte register group
`include "mcit_consts.vh"

module mcit_instr_decoder #(
	parameter PC_W = 16
) (
	// Clock and reset
	input  wire            clock,
	input  wire            rst_n,
	// Run control
	input  wire            execEnable,
	// Program memory, combinational read
	output wire [PC_W-1:0] codeAddr,
	input  wire [7:0]      codeData,
	// Core state, same clock
	input  wire [7:0]      accIn,
	input  wire            carryIn,
	input  wire            bitValueIn,
	input  wire [7:0]      operandIn,
	input  wire [15:0]     dataPointerIn,
	input  wire [7:0]      indirectPointerIn,
	input  wire [1:0]      registerBankSelect,
	// Instruction completion
	output reg             instrDone,
	output reg  [7:0]      instrOpcode,
	output reg  [1:0]      instrLength,
	output reg  [2:0]      instrCycles,
	output reg             branchTaken,
	output reg             foreignOp,
	output reg  [PC_W-1:0] programCounter,
	// Operand addressing
	output reg  [7:0]      operandByte1,
	output reg  [7:0]      operandByte2,
	output reg             directIsSfr,
	output reg             secondDirectIsSfr,
	output reg  [7:0]      bankRegisterAddr,
	output reg             indirectSel,
	// Side effects, pulses or held values set with instrDone
	output reg             bitClearReq,
	output reg             cjneBorrow,
	output reg             dataPointerLoad,
	output reg  [15:0]     dataPointerValue,
	output reg             codeByteLoad,
	output reg  [7:0]      codeByte,
	output reg             callPush,
	output reg  [PC_W-1:0] returnAddr,
	output reg             extDataReq,
	output reg             extWrite,
	output reg  [15:0]     extAddr
);

	// ********************************
	// Decode table
	// ********************************
	function [8:0] decodeOp;
		input [7:0] op;
		begin
			decodeOp = {`MCIT_LEN1, `MCIT_CYC1, `MCIT_CLS_FOREIGN};
			casez (op)
				`MCIT_OP_NOP, `MCIT_OP_SPARE:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC1, `MCIT_CLS_PLAIN};
				`MCIT_OP_CLR_A, `MCIT_OP_CPL_A, `MCIT_OP_SWAP,
				`MCIT_OP_ROT_L, `MCIT_OP_ROT_LC, `MCIT_OP_ROT_R, `MCIT_OP_ROT_RC:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC1, `MCIT_CLS_PLAIN};
				`MCIT_OP_XRL_DIMM:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC3, `MCIT_CLS_PLAIN};
				`MCIT_OP_MOV_A_RN, `MCIT_OP_MOV_RN_A:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC1, `MCIT_CLS_PLAIN};
				`MCIT_OP_MOV_A_RI, `MCIT_OP_MOV_RI_A:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC2, `MCIT_CLS_PLAIN};
				`MCIT_OP_MOV_A_D, `MCIT_OP_MOV_A_I, `MCIT_OP_MOV_RN_D, `MCIT_OP_MOV_RN_I,
				`MCIT_OP_MOV_D_A, `MCIT_OP_MOV_D_RN, `MCIT_OP_MOV_D_RI,
				`MCIT_OP_MOV_RI_D, `MCIT_OP_MOV_RI_I:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC2, `MCIT_CLS_PLAIN};
				`MCIT_OP_MOV_D_D, `MCIT_OP_MOV_D_I:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC3, `MCIT_CLS_PLAIN};
				`MCIT_OP_MOV_DP:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC3, `MCIT_CLS_LDDP};
				`MCIT_OP_MOVC_DP, `MCIT_OP_MOVC_PC:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC3, `MCIT_CLS_MOVC};
				`MCIT_OP_AJMP:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC3, `MCIT_CLS_PAGEJMP};
				`MCIT_OP_ACALL:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC3, `MCIT_CLS_PAGECALL};
				`MCIT_OP_MOVX:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC3, `MCIT_CLS_MOVX};
				`MCIT_OP_PUSH, `MCIT_OP_POP:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC2, `MCIT_CLS_PLAIN};
				`MCIT_OP_XCH_RN:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC1, `MCIT_CLS_PLAIN};
				`MCIT_OP_XCH_RI, `MCIT_OP_XCHD_RI:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC2, `MCIT_CLS_PLAIN};
				`MCIT_OP_XCH_D:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC2, `MCIT_CLS_PLAIN};
				`MCIT_OP_CLR_C, `MCIT_OP_SETB_C, `MCIT_OP_CPL_C:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC1, `MCIT_CLS_PLAIN};
				`MCIT_OP_CLR_B, `MCIT_OP_SETB_B, `MCIT_OP_CPL_B, `MCIT_OP_ANL_CB,
				`MCIT_OP_ANL_CNB, `MCIT_OP_ORL_CB, `MCIT_OP_ORL_CNB,
				`MCIT_OP_MOV_CB, `MCIT_OP_MOV_BC:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC2, `MCIT_CLS_PLAIN};
				`MCIT_OP_JC, `MCIT_OP_JNC, `MCIT_OP_JZ, `MCIT_OP_JNZ:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC2, `MCIT_CLS_CONDFLAG};
				`MCIT_OP_JB, `MCIT_OP_JNB, `MCIT_OP_JBC:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC3, `MCIT_CLS_CONDBIT};
				`MCIT_OP_LJMP:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC4, `MCIT_CLS_LONGJMP};
				`MCIT_OP_LCALL:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC4, `MCIT_CLS_LONGCALL};
				`MCIT_OP_SJMP:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC3, `MCIT_CLS_SJMP};
				`MCIT_OP_JMP_IND:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC3, `MCIT_CLS_JIND};
				`MCIT_OP_CJNE_AD, `MCIT_OP_CJNE_RI:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC4, `MCIT_CLS_CJNE};
				`MCIT_OP_CJNE_AI, `MCIT_OP_CJNE_RN:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC3, `MCIT_CLS_CJNE};
				`MCIT_OP_DJNZ_RN:
					decodeOp = {`MCIT_LEN2, `MCIT_CYC2, `MCIT_CLS_DJNZ};
				`MCIT_OP_DJNZ_D:
					decodeOp = {`MCIT_LEN3, `MCIT_CYC3, `MCIT_CLS_DJNZ};
				default:
					decodeOp = {`MCIT_LEN1, `MCIT_CYC1, `MCIT_CLS_FOREIGN};
			endcase
		end
	endfunction

	// ********************************
	// Sequencer state
	// ********************************
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg            state_q;
	reg  [PC_W-1:0] base_q;
	reg  [PC_W-1:0] pc_q;
	reg  [7:0]      op_q;
	reg  [7:0]      b1_q;
	reg  [7:0]      b2_q;
	reg             ext_q;
	reg  [7:0]      movc_q;
	wire [2:0]      step;
	wire [1:0]      lenNow;
	wire [2:0]      cycNow;
	wire [3:0]      clsNow;
	wire [7:0]      opNow;
	wire [7:0]      byte1;
	wire [7:0]      byte2;
	wire [PC_W-1:0] nextAddr;
	wire [15:0]     relTarget;
	wire [15:0]     pageTarget;
	wire [15:0]     longTarget;
	wire [15:0]     indTarget;
	wire            running;
	wire            isCond;
	wire            lastBase;
	wire            fetching;
	wire            isMovcRead;
	wire [15:0]     movcAddr;
	wire [7:0]      cmpLeft;
	wire [7:0]      cmpRight;
	reg             condTrue;
	reg  [PC_W-1:0] newPc_d;
	wire            finish;
	wire            extend;

	assign running  = (state_q == ST_RUN) && execEnable;
	assign opNow    = (step == `MCIT_STEP0) ? codeData : op_q;
	assign {lenNow, cycNow, clsNow} = decodeOp(opNow);
	// Operand bytes are live from memory during their own fetch cycle
	assign byte1    = (step == `MCIT_STEP1) ? codeData : b1_q;
	assign byte2    = (step == `MCIT_STEP2) ? codeData : b2_q;
	assign nextAddr = base_q + {{(PC_W-2){1'b0}}, lenNow};
	assign fetching = running && (step < {1'b0, lenNow});

	assign movcAddr   = (opNow == `MCIT_OP_MOVC_DP) ? indTarget :
	                    (nextAddr + {8'h00, accIn});
	assign isMovcRead = running && (clsNow == `MCIT_CLS_MOVC) && (step == `MCIT_STEP1);
	// Address mux only; the array behind it is outside this block
	assign codeAddr   = isMovcRead ? movcAddr : pc_q;

	// ********************************
	// Branch conditions
	// ********************************
	assign isCond = (clsNow == `MCIT_CLS_CONDFLAG) || (clsNow == `MCIT_CLS_CONDBIT) ||
	                (clsNow == `MCIT_CLS_CJNE) || (clsNow == `MCIT_CLS_DJNZ);
	assign cmpLeft  = (opNow == `MCIT_OP_CJNE_AD) ? accIn :
	                  (opNow == `MCIT_OP_CJNE_AI) ? accIn : operandIn;
	assign cmpRight = (opNow == `MCIT_OP_CJNE_AD) ? operandIn : byte1;

	always @* begin
		condTrue = 1'b0;
		case (clsNow)
			`MCIT_CLS_CONDFLAG: begin
				case (opNow)
					`MCIT_OP_JC:  condTrue = carryIn;
					`MCIT_OP_JNC: condTrue = ~carryIn;
					`MCIT_OP_JZ:  condTrue = (accIn == `MCIT_BYTE_RESET);
					default:      condTrue = (accIn != `MCIT_BYTE_RESET);
				endcase
			end
			`MCIT_CLS_CONDBIT:
				condTrue = (opNow == `MCIT_OP_JNB) ? ~bitValueIn : bitValueIn;
			`MCIT_CLS_CJNE:
				condTrue = (cmpLeft != cmpRight);
			`MCIT_CLS_DJNZ:
				condTrue = (operandIn != `MCIT_DJNZ_LAST);
			default:
				condTrue = 1'b0;
		endcase
	end

	// Untaken branch ends on its base count, taken adds one cycle
	assign lastBase = running && !ext_q && (step == (cycNow - `MCIT_CYC1));
	assign extend   = lastBase && isCond && condTrue;
	assign finish   = (lastBase && !extend) || (running && ext_q);

	always @* begin
		newPc_d = nextAddr;
		case (clsNow)
			`MCIT_CLS_CONDFLAG, `MCIT_CLS_DJNZ, `MCIT_CLS_CONDBIT, `MCIT_CLS_CJNE: begin
				if (ext_q) begin
					newPc_d = relTarget;
				end
			end
			`MCIT_CLS_SJMP:                          newPc_d = relTarget;
			`MCIT_CLS_PAGEJMP, `MCIT_CLS_PAGECALL:   newPc_d = pageTarget;
			`MCIT_CLS_LONGJMP, `MCIT_CLS_LONGCALL:   newPc_d = longTarget;
			`MCIT_CLS_JIND:                          newPc_d = indTarget;
			default:                                 newPc_d = nextAddr;
		endcase
	end

	// ********************************
	// Submodules
	// ********************************
	mcit_step_counter #(
		.STEP_W (3)
	) mcit_step_counter_i (
		.clock   (clock),
		.rst_n   (rst_n),
		.clear   (finish),
		.advance (running),
		.step    (step)
	);

	mcit_target_calc mcit_target_calc_i (
		.nextAddr      (nextAddr),
		.opcode        (opNow),
		.relByte       ((lenNow == `MCIT_LEN2) ? byte1 : byte2),
		.byte1         (byte1),
		.byte2         (byte2),
		.accIn         (accIn),
		.dataPointerIn (dataPointerIn),
		.relTarget     (relTarget),
		.pageTarget    (pageTarget),
		.longTarget    (longTarget),
		.indTarget     (indTarget)
	);

	// ********************************
	// Sequencer
	// ********************************
	always @(posedge clock) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			base_q  <= `MCIT_PC_RESET;
			pc_q    <= `MCIT_PC_RESET;
			op_q    <= `MCIT_BYTE_RESET;
			b1_q    <= `MCIT_BYTE_RESET;
			b2_q    <= `MCIT_BYTE_RESET;
			ext_q   <= 1'b0;
			movc_q  <= `MCIT_BYTE_RESET;
		end else begin
			state_q <= ST_RUN;
			if (running) begin
				if (step == `MCIT_STEP0) begin
					op_q <= codeData;
				end
				if (step == `MCIT_STEP1) begin
					b1_q <= codeData;
				end
				if (step == `MCIT_STEP2) begin
					b2_q <= codeData;
				end
				if (isMovcRead) begin
					movc_q <= codeData;
				end
				if (fetching) begin
					pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
				end
				if (extend) begin
					ext_q <= 1'b1;
				end
				if (finish) begin
					ext_q  <= 1'b0;
					pc_q   <= newPc_d;
					base_q <= newPc_d;
				end
			end
		end
	end

	// ********************************
	// Operand addressing outputs
	// ********************************
	always @(posedge clock) begin
		if (!rst_n) begin
			operandByte1      <= `MCIT_BYTE_RESET;
			operandByte2      <= `MCIT_BYTE_RESET;
			directIsSfr       <= 1'b0;
			secondDirectIsSfr <= 1'b0;
			bankRegisterAddr  <= `MCIT_BYTE_RESET;
			indirectSel       <= 1'b0;
		end else if (running) begin
			if (step == `MCIT_STEP0) begin
				indirectSel <= codeData[0];
				// Register forms use three index bits, pointer forms one
				if (codeData[3]) begin
					bankRegisterAddr <= {3'h0, registerBankSelect, codeData[2:0]};
				end else begin
					bankRegisterAddr <= {3'h0, registerBankSelect, 2'h0, codeData[0]};
				end
			end
			if (step == `MCIT_STEP1) begin
				operandByte1 <= codeData;
				directIsSfr  <= codeData[`MCIT_SFR_BIT];
			end
			if (step == `MCIT_STEP2) begin
				operandByte2      <= codeData;
				secondDirectIsSfr <= codeData[`MCIT_SFR_BIT];
			end
		end
	end

	// ********************************
	// Completion and side effects
	// ********************************
	always @(posedge clock) begin
		if (!rst_n) begin
			instrDone        <= 1'b0;
			instrOpcode      <= `MCIT_BYTE_RESET;
			instrLength      <= 2'h0;
			instrCycles      <= 3'h0;
			branchTaken      <= 1'b0;
			foreignOp        <= 1'b0;
			programCounter   <= `MCIT_PC_RESET;
			bitClearReq      <= 1'b0;
			cjneBorrow       <= 1'b0;
			dataPointerLoad  <= 1'b0;
			dataPointerValue <= 16'h0000;
			codeByteLoad     <= 1'b0;
			codeByte         <= `MCIT_BYTE_RESET;
			callPush         <= 1'b0;
			returnAddr       <= `MCIT_PC_RESET;
			extDataReq       <= 1'b0;
			extWrite         <= 1'b0;
			extAddr          <= 16'h0000;
		end else begin
			instrDone       <= finish;
			bitClearReq     <= finish && ext_q && (opNow == `MCIT_OP_JBC);
			dataPointerLoad <= finish && (clsNow == `MCIT_CLS_LDDP);
			codeByteLoad    <= finish && (clsNow == `MCIT_CLS_MOVC);
			callPush        <= finish && ((clsNow == `MCIT_CLS_PAGECALL) ||
			                              (clsNow == `MCIT_CLS_LONGCALL));
			extDataReq      <= finish && (clsNow == `MCIT_CLS_MOVX);
			if (finish) begin
				instrOpcode      <= opNow;
				instrLength      <= lenNow;
				instrCycles      <= ext_q ? (cycNow + `MCIT_CYC1) : cycNow;
				branchTaken      <= ext_q || (newPc_d != nextAddr);
				foreignOp        <= (clsNow == `MCIT_CLS_FOREIGN);
				programCounter   <= newPc_d;
				cjneBorrow       <= (cmpLeft < cmpRight);
				dataPointerValue <= {byte1, byte2};
				codeByte         <= movc_q;
				returnAddr       <= nextAddr;
				extWrite         <= opNow[4];
				// Pointer forms carry an 8-bit address, pointer-register data below
				extAddr          <= opNow[1] ? {8'h00, indirectPointerIn} : dataPointerIn;
			end
		end
	end

endmodule

/* testbench/mcit_instr_decoder_assertions.sv */
// ************************
// Decoder timing checks
// ************************
module mcit_instr_decoder_assertions (
	// Clock and reset
	input logic       clock,
	input logic       rst_n,
	// Completion record
	input logic       instrDone,
	input logic [7:0] instrOpcode,
	input logic [1:0] instrLength,
	input logic [2:0] instrCycles,
	input logic       branchTaken,
	// Side-effect pulses
	input logic       bitClearReq,
	input logic       dataPointerLoad,
	input logic       codeByteLoad,
	input logic       extDataReq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Previous instruction ends, two quiet cycles, next ends
	sequence three_gap;
		instrDone ##1 !instrDone [*2] ##1 instrDone;
	endsequence
	acc_op_timing_a:
	assert property (instrDone && instrOpcode inside {8'h03, 8'hE4} |->
		instrLength == 2'h1 && instrCycles == 3'h1) else $error("acc op timing");
	xor_direct_a:
	assert property (instrDone && instrOpcode == 8'h63 |->
		instrLength == 2'h3 && instrCycles == 3'h3) else $error("xor timing");
	spare_nop_a:
	assert property (instrDone && instrOpcode == 8'hA5 |->
		instrLength == 2'h1 && instrCycles == 3'h1) else $error("spare opcode timing");
	pointer_load_a:
	assert property (dataPointerLoad |-> instrDone && instrOpcode == 8'h90 &&
		instrLength == 2'h3 && instrCycles == 3'h3) else $error("pointer load");
	code_read_a:
	assert property (codeByteLoad |-> instrDone && instrLength == 2'h1 &&
		instrCycles == 3'h3) else $error("code read timing");
	ext_move_a:
	assert property (extDataReq |-> instrDone && instrLength == 2'h1 &&
		instrCycles == 3'h3) else $error("external move timing");
	bit_clear_a:
	assert property (bitClearReq |-> instrDone && instrOpcode == 8'h10 && branchTaken &&
		instrCycles == 3'h4) else $error("bit clear");
	step_gap_a:
	assert property (three_gap |-> instrCycles == 3'h3) else $error("cycle count");
endmodule

bind mcit_instr_decoder mcit_instr_decoder_assertions mcit_instr_decoder_assertions_i (
	.clock, .rst_n, .instrDone, .instrOpcode, .instrLength, .instrCycles, .branchTaken,
	.bitClearReq, .dataPointerLoad, .codeByteLoad, .extDataReq);

/* testbench/mcit_instr_decoder_tb_top.sv */
// ************************
// Random program bench
// ************************
module mcit_instr_decoder_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        carryIn, bitValueIn, instrDone, branchTaken, foreignOp;
	logic [7:0]  accIn, operandIn, codeData, instrOpcode, bankRegisterAddr;
	logic [1:0]  registerBankSelect, instrLength;
	logic [2:0]  instrCycles;
	logic [15:0] dataPointerIn, codeAddr, programCounter, dataPointerValue;
	logic [7:0]  codeMem [0:65535];
	logic [47:0] expQ [$];
	logic [35:0] drvQ [$];
	logic [47:0] x;
	int          n_mismatch, cmp_count, gap, nDone, tick;
	// Opcode, length, base cycles, branch kind
	logic [19:0] tbl [32] = '{20'hE_4110, 20'h0_3110, 20'h6_3330, 20'h8_5330, 20'h9_0330,
		20'h9_3130, 20'hE_0130, 20'hF_2130, 20'hC_0220, 20'hC_6120, 20'hC_5220, 20'hD_2220,
		20'hA_5110, 20'hE_8110, 20'h4_0221, 20'h5_0222, 20'h6_0223, 20'h7_0224, 20'h2_0335,
		20'h3_0336, 20'h1_0337, 20'hB_4338, 20'hB_534E, 20'hB_634F, 20'hB_833F, 20'hD_8229,
		20'hD_5339, 20'h8_023A, 20'h0_234B, 20'h0_123C, 20'h1_234B, 20'h7_313D};
	assign codeData = codeMem[codeAddr];
	always #12.5 clock = ~clock;
	mcit_instr_decoder mcit_instr_decoder_i (.clock(clock), .rst_n(rst_n), .execEnable(1'b1),
		.codeAddr(codeAddr), .codeData(codeData), .accIn(accIn), .carryIn(carryIn),
		.bitValueIn(bitValueIn), .operandIn(operandIn), .dataPointerIn(dataPointerIn),
		.indirectPointerIn(8'h00), .registerBankSelect(registerBankSelect),
		.instrDone(instrDone), .instrOpcode(instrOpcode), .instrLength(instrLength),
		.instrCycles(instrCycles), .branchTaken(branchTaken), .foreignOp(foreignOp),
		.programCounter(programCounter), .operandByte1(), .operandByte2(), .directIsSfr(),
		.secondDirectIsSfr(), .bankRegisterAddr(bankRegisterAddr), .indirectSel(),
		.bitClearReq(), .cjneBorrow(), .dataPointerLoad(), .dataPointerValue(dataPointerValue),
		.codeByteLoad(), .codeByte(), .callPush(), .returnAddr(), .extDataReq(), .extWrite(),
		.extAddr());
	task automatic chk(input logic [35:0] got, input logic [35:0] want);
		cmp_count++;
		if (got !== want) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, want);
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(negedge clock) begin
		tick++;
		if (tick == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	always @(negedge clock) if (rst_n) begin
		gap++;
		if (instrDone === 1'b1) begin
			x = expQ.pop_front();
			chk({instrOpcode, instrLength, instrCycles, programCounter, branchTaken}, x[29:0]);
			if (nDone > 0) chk(gap, x[19:17]);
			if (x[29:22] inside {8'hE8, 8'hD8, 8'hB8, 8'hC6, 8'hB6})
				chk(bankRegisterAddr, {3'h0, x[31:30], 3'h0});
			if (x[29:22] == 8'h90) chk(dataPointerValue, x[47:32]);
			chk(foreignOp, 1'b0);
			gap = 0;
			nDone++;
			if (drvQ.size() > 0)
				{carryIn, bitValueIn, accIn, operandIn, dataPointerIn, registerBankSelect} = drvQ.pop_front();
		end
	end
	initial begin
		logic [19:0] e;
		logic [15:0] pc, nx, t;
		logic [7:0]  op, r, b1, a, o;
		logic        c, bv, tk;
		void'($urandom(81));
		pc = 16'h0000;
		foreach (codeMem[j]) codeMem[j] = 8'h00;
		// Forward-only targets keep the prebuilt program from overwriting itself
		repeat (60) begin
			e = tbl[$urandom % 32];
			op = e[19:12];
			nx = pc + e[11:8];
			r = 8'($urandom % 31 + 1);
			{c, bv} = 2'($urandom);
			a = 8'($urandom % 2);
			o = 8'($urandom % 2);
			b1 = (e[11:8] == 4'h3 && e[3:0] != 4'h0) ? 8'($urandom % 2) : r;
			t = nx + (e[3:0] == 4'hB ? {r, 3'b000} : e[3:0] == 4'hD ? a : r);
			if (e[3:0] == 4'hC && t[15:11] != nx[15:11]) t = nx;
			if (e[3:0] == 4'hC) {op[7:5], b1} = t[10:0];
			if (e[3:0] == 4'hB) {b1, r} = t;
			case (e[3:0])
				4'h1: tk = c;
				4'h2: tk = !c;
				4'h3: tk = a == 8'h00;
				4'h4: tk = a != 8'h00;
				4'h5, 4'h7: tk = bv;
				4'h6: tk = !bv;
				4'h8: tk = a != b1;
				4'h9: tk = o != 8'h01;
				4'hE: tk = a != o;
				4'hF: tk = o != b1;
				default: tk = e[3:0] > 4'h9;
			endcase
			codeMem[pc] = op;
			codeMem[pc + 16'h0001] = b1;
			codeMem[pc + 16'h0002] = r;
			pc = tk ? t : nx;
			expQ.push_back({b1, r, r[1:0], op, e[9:8],
				e[6:4] + 3'(tk && (e[3:0] < 4'hA || e[3:0] > 4'hD)),
				pc, tk && t != nx});
			// Carry, bit value, A, operand, data pointer and bank field are driven; no reserved bit is ever set
			drvQ.push_back({c, bv, a, o, nx, r[1:0]});
		end
		{carryIn, bitValueIn, accIn, operandIn, dataPointerIn, registerBankSelect} = drvQ.pop_front();
		repeat (8) @(negedge clock);
		chk({instrDone, programCounter}, 17'h0_0000);
		rst_n = 1'b1;
		// Wait on the opposite edge so the last check never races a stray fetch
		while (expQ.size() > 0) @(posedge clock);
		$display("Random program of 60 instructions done");
		end_sim();
	end
endmodule
